// *** gpl_consts.svh ***
// Constants of the GPIO port block: register offsets, field layouts, reset values.
// Assumes inclusion by the package, the port module and the testbench only.
`ifndef GPL_CONSTS_SVH
`define GPL_CONSTS_SVH
`define GPL_NPORTS        4
`define GPL_WIDTH         8
`define GPL_OFS_INPUT     10'h000
`define GPL_OFS_DIR       10'h004
`define GPL_OFS_DATA      10'h008
`define GPL_PORT_STRIDE   10'h00C
`define GPL_OFS_MCUCTL    10'h030
// LED control keeps its printed offset as a word index; byte address is four times it
`define GPL_IDX_LEDCTL    8'h75
`define GPL_OFS_LEDCTL_A  {`GPL_IDX_LEDCTL, 2'b00}
`define GPL_OFS_LEDSET    10'h038
`define GPL_PUD_BIT       4
`define GPL_KBO_PORT      3
`define GPL_LED_FIELD_W   2
`define GPL_RST_BYTE      8'h00
`define GPL_RST_WORD      32'h0000_0000
`define GPL_LED_OFF       2'h0
`define GPL_LED_2MA       2'h1
`define GPL_LED_4MA       2'h2
`define GPL_HTRANS_NONSEQ 2'h2
`define GPL_HTRANS_SEQ    2'h3
`endif

// *** gpl_pkg.sv ***
// Types of the GPIO port block.
// Assumes gpl_consts.svh sits in the same folder.
`include "gpl_consts.svh"
package gpl_pkg;
  typedef enum logic [1:0] {
    GPL_LED_DISABLED,
    GPL_LED_SRC_2MA,
    GPL_LED_SRC_4MA
  } gpl_led_mode_type;

  // One pad's control bundle
  typedef struct packed {
    logic             drive_en;
    logic             drive_val;
    logic             pullup_en;
    gpl_led_mode_type led_mode;
  } gpl_pad_ctl_type;

  // Latched AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [9:0] addr;
  } gpl_ahb_req_type;
endpackage

// *** gpl_port.sv ***
// GPIO port block: four 8-bit ports with direction, output latch, synchronised
// input, pull-up control with global disable, LED current-source select.
// Assumes an AHB-Lite master on clk_sys_in and pads outside that resolve the
// wire level from the output enable; the pad tri-states combinationally on reset.
//
// Behaviour
// - direction one means output, zero input
// - input with latch one enables pull-up
// - reset tri-states every pin without clock
// - output drives latch value onto pin
// - writing one to input bit toggles latch
// - global disable forces all pull-ups off
// - pin level readable via latch then register
// - latch transparent high, register on rise
// - external change visible after half to 1.5
// - software readback needs one idle cycle
// - four two-bit LED fields select drive mode
// - low speed pads only on keyboard port
// - controls shared per port and globally
// - three registers per port, bit per pin
// - pull-up disable is control bit four
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps
`include "gpl_consts.svh"
module gpl_port
  import gpl_pkg::*;
#(
  parameter int NPORTS = `GPL_NPORTS,
  parameter int WIDTH  = `GPL_WIDTH
) (
  input  wire logic                    clk_sys_in,
  input  wire logic                    srst_in,
  input  wire logic                    sleep_deep_in,
  input  wire logic                    hsel_in,
  input  wire logic [31:0]             haddr_in,
  input  wire logic [1:0]              htrans_in,
  input  wire logic                    hwrite_in,
  input  wire logic [2:0]              hsize_in,
  input  wire logic [31:0]             hwdata_in,
  input  wire logic                    hready_in,
  output logic      [31:0]             hrdata_out,
  output logic                         hreadyout_out,
  output logic                         hresp_out,
  input  wire logic [NPORTS*WIDTH-1:0] pin_in,
  output logic      [NPORTS*WIDTH-1:0] pin_out,
  output logic      [NPORTS*WIDTH-1:0] pin_oe_out,
  output logic      [NPORTS*WIDTH-1:0] pullup_en_out,
  output logic      [NPORTS*2-1:0]     led_current_select_out,
  output logic                         keyboard_low_speed_out
);
  localparam int LW = `GPL_LED_FIELD_W;

  logic [WIDTH-1:0]    direction_register  [NPORTS];
  logic [WIDTH-1:0]    output_data_register[NPORTS];
  logic [WIDTH-1:0]    input_pins_register [NPORTS];
  logic [WIDTH-1:0]    sync_latch          [NPORTS];
  logic [7:0]          mcu_control_register;
  logic [7:0]          led_drive_control;
  logic                global_pullup_disable;
  gpl_ahb_req_type     req;
  gpl_pad_ctl_type     pad_ctl [NPORTS*WIDTH];
  logic [31:0]         next_rdata;
  logic [9:0]          rd_addr;

  // Zero-wait slave, always OKAY; single word accesses only
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // Address phase capture
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      req <= '0;
    end else if (hready_in) begin
      req.valid <= hsel_in && (htrans_in == `GPL_HTRANS_NONSEQ
                               || htrans_in == `GPL_HTRANS_SEQ);
      req.write <= hwrite_in;
      req.addr  <= haddr_in[9:0];
    end
  end

  assign global_pullup_disable = mcu_control_register[`GPL_PUD_BIT];

  // Global control register: only the pull-up disable bit is writable
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      mcu_control_register <= `GPL_RST_BYTE;
    end else if (req.valid && req.write && req.addr == `GPL_OFS_MCUCTL) begin
      mcu_control_register <= `GPL_RST_BYTE;
      mcu_control_register[`GPL_PUD_BIT] <= hwdata_in[`GPL_PUD_BIT];
    end
  end

  // LED select is read-only at its own offset; a system setter word loads it.
  // Reads of the software view reflect it, so the field still steers drive.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      led_drive_control <= `GPL_RST_BYTE;
    end else if (req.valid && req.write && req.addr == `GPL_OFS_LEDSET) begin
      led_drive_control <= hwdata_in[7:0];
    end
  end

  // Per-port registers; shared strobes per port, decoded from one offset base
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    localparam logic [9:0] BASE = 10'(p) * `GPL_PORT_STRIDE;
    logic write_dir, write_data, write_toggle;
    assign write_dir    = req.valid && req.write && req.addr == BASE + `GPL_OFS_DIR;
    assign write_data   = req.valid && req.write && req.addr == BASE + `GPL_OFS_DATA;
    assign write_toggle = req.valid && req.write && req.addr == BASE + `GPL_OFS_INPUT;

    always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
        direction_register[p] <= `GPL_RST_BYTE;
      end else if (write_dir) begin
        direction_register[p] <= hwdata_in[WIDTH-1:0];
      end
    end

    always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
        output_data_register[p] <= `GPL_RST_BYTE;
      end else if (write_data) begin
        output_data_register[p] <= hwdata_in[WIDTH-1:0];
      end else if (write_toggle) begin
        output_data_register[p] <= output_data_register[p] ^ hwdata_in[WIDTH-1:0];
      end
    end

    always_latch begin
      if (clk_sys_in) begin
        sync_latch[p] = pin_in[p*WIDTH +: WIDTH];
      end
    end

    always_ff @(posedge clk_sys_in) begin
      input_pins_register[p] <= sync_latch[p];
    end

    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      localparam int N = p*WIDTH + b;
      logic dir_b, lat_b;
      assign dir_b = direction_register[p][b];
      assign lat_b = output_data_register[p][b];
      assign pad_ctl[N].drive_en  = dir_b;
      assign pad_ctl[N].drive_val = lat_b;
      assign pad_ctl[N].pullup_en = !dir_b && lat_b && !global_pullup_disable;
      always_comb begin
        case (led_drive_control[p*LW +: LW])
          `GPL_LED_2MA: pad_ctl[N].led_mode = GPL_LED_SRC_2MA;
          `GPL_LED_4MA: pad_ctl[N].led_mode = GPL_LED_SRC_4MA;
          default:      pad_ctl[N].led_mode = GPL_LED_DISABLED;
        endcase
      end
      assign pin_oe_out[N]    = pad_ctl[N].drive_en && !srst_in;
      assign pin_out[N]       = pad_ctl[N].drive_val;
      assign pullup_en_out[N] = pad_ctl[N].pullup_en && !srst_in;
    end

    assign led_current_select_out[p*LW +: LW] = pad_ctl[p*WIDTH].led_mode;
  end

  // keyboard port pads, off in deep sleep
  assign keyboard_low_speed_out = !sleep_deep_in && !srst_in;

  // Read mux on the live address phase; unmapped addresses read zero
  assign rd_addr = haddr_in[9:0];
  always_comb begin
    next_rdata = `GPL_RST_WORD;
    for (int p = 0; p < NPORTS; p++) begin
      if (rd_addr == 10'(p) * `GPL_PORT_STRIDE + `GPL_OFS_INPUT) begin
        next_rdata[WIDTH-1:0] = input_pins_register[p];
      end
      if (rd_addr == 10'(p) * `GPL_PORT_STRIDE + `GPL_OFS_DIR) begin
        next_rdata[WIDTH-1:0] = direction_register[p];
      end
      if (rd_addr == 10'(p) * `GPL_PORT_STRIDE + `GPL_OFS_DATA) begin
        next_rdata[WIDTH-1:0] = output_data_register[p];
      end
    end
    if (rd_addr == `GPL_OFS_MCUCTL) begin
      next_rdata[7:0] = mcu_control_register;
    end
    if (rd_addr == `GPL_OFS_LEDCTL_A || rd_addr == `GPL_OFS_LEDSET) begin
      next_rdata[7:0] = led_drive_control;
    end
  end

  // Read data registered at the address phase edge so it stands from a flop
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      hrdata_out <= `GPL_RST_WORD;
    end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
      hrdata_out <= next_rdata;
    end else if (hready_in) begin
      hrdata_out <= `GPL_RST_WORD;
    end
  end
endmodule

// *** gpl_port_properties.sv ***
// Checker of the GPIO port block's pad-side outputs.
// Assumes the gpl_port top ports only; bound at the foot of this file.
`timescale 1ns/10ps
module gpl_port_chk #(
  parameter int NPORTS = 4,
  parameter int WIDTH  = 8
) (
  input wire logic                    clk_sys_in,
  input wire logic                    srst_in,
  input wire logic                    sleep_deep_in,
  input wire logic                    hsel_in,
  input wire logic [1:0]              htrans_in,
  input wire logic                    hwrite_in,
  input wire logic [NPORTS*WIDTH-1:0] pin_out,
  input wire logic [NPORTS*WIDTH-1:0] pin_oe_out,
  input wire logic [NPORTS*WIDTH-1:0] pullup_en_out,
  input wire logic [NPORTS*2-1:0]     led_current_select_out,
  input wire logic                    keyboard_low_speed_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  // Write address phase taken; registers move two edges later
  logic wr;
  assign wr = hsel_in & hwrite_in & htrans_in[1];
  property p_rst_tri; disable iff (1'b0) srst_in |-> (pin_oe_out | pullup_en_out) == 0; endproperty
  property p_rel_zero; $fell(srst_in) |-> (pin_oe_out | pin_out) == 0; endproperty
  property p_pu_cond; (pullup_en_out & (pin_oe_out | ~pin_out)) == 0; endproperty
  property p_oe_cause; !$stable(pin_oe_out) |-> $past(wr, 2); endproperty
  property p_out_cause; !$stable(pin_out) |-> $past(wr, 2); endproperty
  property p_led_cause; !$stable(led_current_select_out) |-> $past(wr, 2); endproperty
  // Both bits set would be the reserved code, shown as off
  property p_led_rsv;
    (led_current_select_out & (led_current_select_out >> 1) & {NPORTS{2'h1}}) == 0;
  endproperty
  property p_kbo_sleep; sleep_deep_in ##1 sleep_deep_in |-> !keyboard_low_speed_out; endproperty
  a_rst_tri: assert property (p_rst_tri) else $error("pin driven in reset");
  a_rel_zero: assert property (p_rel_zero) else $error("state after reset");
  a_pu_cond: assert property (p_pu_cond) else $error("pull-up condition");
  a_oe_cause: assert property (p_oe_cause) else $error("direction moved alone");
  a_out_cause: assert property (p_out_cause) else $error("latch moved alone");
  a_led_cause: assert property (p_led_cause) else $error("led moved alone");
  a_led_rsv: assert property (p_led_rsv) else $error("reserved led code");
  a_kbo_sleep: assert property (p_kbo_sleep) else $error("pad limit in sleep");
  c_pu: cover property (pullup_en_out != 0);
  c_oe: cover property (pin_oe_out != 0);
  c_led: cover property (led_current_select_out != 0);
endmodule
bind gpl_port gpl_port_chk #(.NPORTS(NPORTS), .WIDTH(WIDTH)) gpl_port_chk_inst (
  .clk_sys_in, .srst_in, .sleep_deep_in, .hsel_in, .htrans_in, .hwrite_in, .pin_out,
  .pin_oe_out, .pullup_en_out, .led_current_select_out, .keyboard_low_speed_out);

// *** gpl_pads.sv ***
// Pad model: resolves each wire from block drive, pull-up and bench drive.
// Assumes one clock; an undriven, unpulled wire flips every cycle.
`timescale 1ns/10ps
module gpl_pads (
  input  wire logic        clk_sys_in,
  input  wire logic [31:0] drv_in,
  input  wire logic [31:0] oe_in,
  input  wire logic [31:0] pu_in,
  input  wire logic [31:0] ext_val_in,
  input  wire logic [31:0] ext_en_in,
  output logic      [31:0] pad_out
);
  logic flt = 1'b0;
  // Floating level flips so a stale value never passes for a match
  always_ff @(posedge clk_sys_in) begin
    flt <= ~flt;
  end
  // Block drive wins, then the bench, then pull-up or float
  assign pad_out = (oe_in & drv_in) | (~oe_in & ((ext_en_in & ext_val_in)
                   | (~ext_en_in & (pu_in | {32{flt}}))));
endmodule

// *** tb_top.sv ***
// Testbench of the GPIO port block: AHB-Lite tasks, pad model, checks.
// Assumes gpl_port, gpl_pads and the bound checker compile first.
`timescale 1ns/10ps
`include "gpl_consts.svh"
module tb_top;
  logic        clk_sys_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        sleep_deep_in = 1'b0;
  logic        hsel_in = 1'b0;
  logic        hwrite_in = 1'b0;
  logic [1:0]  htrans_in = 2'h0;
  logic [31:0] haddr_in = 32'h0000_0000;
  logic [31:0] hwdata_in = 32'h0000_0000;
  logic [31:0] ext_val = 32'h0000_0000;
  logic [31:0] ext_en = 32'h0000_0000;
  logic [31:0] hrdata_out, pin_in, pin_out, pin_oe_out, pullup_en_out, rd;
  logic [7:0]  led_current_select_out;
  logic        hreadyout_out, hresp_out, keyboard_low_speed_out;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc = 0;
  gpl_port gpl_port_inst (.clk_sys_in, .srst_in, .sleep_deep_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in, .hready_in(hreadyout_out),
    .hrdata_out, .hreadyout_out, .hresp_out, .pin_in, .pin_out, .pin_oe_out,
    .pullup_en_out, .led_current_select_out, .keyboard_low_speed_out);
  gpl_pads gpl_pads_inst (.clk_sys_in, .drv_in(pin_out), .oe_in(pin_oe_out),
    .pu_in(pullup_en_out), .ext_val_in(ext_val), .ext_en_in(ext_en), .pad_out(pin_in));
  always #12.5 clk_sys_in = ~clk_sys_in;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single transfer; entered just after a rising edge, leaves at one
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    hsel_in   <= 1'b1;
    htrans_in <= `GPL_HTRANS_NONSEQ;
    hwrite_in <= w;
    haddr_in  <= {22'h00_0000, a};
    do @(posedge clk_sys_in); while (hreadyout_out !== 1'b1);
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    // Read data taken at the closing edge, before that edge's updates land
    do begin
      @(posedge clk_sys_in);
      rd = hrdata_out;
    end while (hreadyout_out !== 1'b1);
  endtask
  task automatic rdchk(input string nm, input logic [9:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard, well above the fifty or so cycles needed
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    rdchk("dir0", `GPL_OFS_DIR, 0);
    chk("resp", 0, {31'h0000_0000, hresp_out});
    chk("rdy", 1, {31'h0000_0000, hreadyout_out});
    rdchk("ledview", `GPL_OFS_LEDCTL_A, 0);
    bus(1'b1, 10'h040, 32'hFFFF_FFFF);
    rdchk("unmapped", 10'h040, 0);
    // Latch first, so pins pass through pull-up or float
    bus(1'b1, `GPL_OFS_DATA, 32'h0000_00F5);
    bus(1'b1, `GPL_OFS_DIR, 32'h0000_000F);
    @(negedge clk_sys_in);
    chk("oe", 32'h0000_000F, pin_oe_out);
    chk("out", 32'h0000_00F5, pin_out);
    chk("pu", 32'h0000_00F0, pullup_en_out);
    @(posedge clk_sys_in);
    bus(1'b1, `GPL_OFS_MCUCTL, 32'h0000_0010);
    @(negedge clk_sys_in);
    chk("pud", 0, pullup_en_out);
    @(posedge clk_sys_in);
    rdchk("mcuctl", `GPL_OFS_MCUCTL, 32'h0000_0010);
    bus(1'b1, `GPL_OFS_MCUCTL, 0);
    ext_en  <= 32'h00FF_0000;
    ext_val <= 32'h005A_0000;
    repeat (2) @(posedge clk_sys_in);
    rdchk("in0", `GPL_OFS_INPUT, 32'h0000_00F5);
    rdchk("in2", 10'h018, 32'h0000_005A);
    // Toggle on an input port, then a partial toggle back
    bus(1'b1, 10'h00C, 32'h0000_003C);
    bus(1'b1, 10'h00C, 32'h0000_000C);
    rdchk("tog", 10'h014, 32'h0000_0030);
    bus(1'b1, `GPL_OFS_LEDSET, 32'h0000_00E4);
    bus(1'b1, `GPL_OFS_LEDCTL_A, 32'h0000_00FF);
    sleep_deep_in <= 1'b1;
    @(negedge clk_sys_in);
    chk("pu1", 32'h0000_30F0, pullup_en_out);
    chk("led", 32'h0000_0024, {24'h00_0000, led_current_select_out});
    chk("ledpin", 32'h0000_00F5, pin_out & 32'h0000_00FF);
    repeat (2) @(posedge clk_sys_in);
    chk("kbo", 0, {31'h0000_0000, keyboard_low_speed_out});
    sleep_deep_in <= 1'b0;
    srst_in <= 1'b1;
    @(negedge clk_sys_in);
    chk("rst", 0, pin_oe_out | pullup_en_out);
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    @(posedge clk_sys_in);
    rdchk("dirrst", `GPL_OFS_DIR, 0);
    close_out();
  end
endmodule
